// File: hdl/pulse_count_led_config_pkg.sv
// Summary of operation
// - latch count after pin high past timeout
// - counts 17 and up are address minus 17
// - counts 1 to 16 are data for address
// - address held across data writes
// - pin low past timeout forces shutdown
// - shutdown clears address, data registers to one
// - only addresses 0, 3, 4, 5 are mapped
// - address 0 sets common level on all channels
// - level code 1 full scale, 16 minimum
// - one scale active, 20 mA after start-up
// - address 3 data selects scale or low mode
// - low mode takes level from address 4
// - address 4 data sets low level
// - pump starts 1X, low cathode steps 1.5X
// - from 1.5X steps to 2X on low cathode
// - floating unused cathode leaves pump in 2X
// - pulse activity enables pump, values set currents
// - regulator enables independent of each other, pump
// - address 5 enables invert data minus one
package pulse_count_led_config_pkg;
   // timing
   localparam int unsigned CLK_MHZ = 20;
   localparam int unsigned LATCH_TIMEOUT_US = 500;
   localparam int unsigned OFF_TIMEOUT_US = 500;
   localparam int unsigned LATCH_TIMEOUT_CYC = LATCH_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned OFF_TIMEOUT_CYC = OFF_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned MODE_SETTLE_CYC = 16;
   localparam int unsigned TIMER_W = 14;
   // edge counter
   localparam int unsigned EDGE_W = 5;
   localparam logic [4:0] EDGE_MAX = 5'h1F;
   localparam logic [4:0] DATA_MAX_EDGES = 5'h10;
   localparam logic [4:0] ADDR_BASE_EDGES = 5'h11;
   // register offsets
   localparam logic [3:0] ADDR_COMMON_LEVEL = 4'h0;
   localparam logic [3:0] ADDR_SCALE = 4'h3;
   localparam logic [3:0] ADDR_LOW_LEVEL = 4'h4;
   localparam logic [3:0] ADDR_CHAN_EN = 4'h5;
   localparam logic [3:0] ADDR_RESET = 4'h0;
   // fields hold data minus one; data value 1 is field 0
   localparam logic [3:0] DATA_RESET_FIELD = 4'h0;
   localparam logic [3:0] SCALE_MAX_FIELD = 4'h3;
   localparam logic [3:0] LOW_MAX_FIELD = 4'h3;
   // current scale choices, data 1..4
   typedef enum logic [3:0] {
      SCALE_20MA = 4'h1,
      SCALE_30MA = 4'h2,
      SCALE_15MA = 4'h4,
      SCALE_LOW = 4'h8
   } scale_e;
   // charge pump gain
   typedef enum logic [2:0] {
      PUMP_1X = 3'h1,
      PUMP_1P5X = 3'h2,
      PUMP_2X = 3'h4
   } pump_mode_e;
   // link state
   typedef enum logic [1:0] {
      LINK_OFF = 2'h1,
      LINK_ON = 2'h2
   } link_state_e;
endpackage : pulse_count_led_config_pkg

// File: hdl/pulse_count_led_config.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_count_led_config #(
   parameter logic [13:0] LATCH_CYCLES =
      14'(pulse_count_led_config_pkg::LATCH_TIMEOUT_CYC),
   parameter logic [13:0] OFF_CYCLES =
      14'(pulse_count_led_config_pkg::OFF_TIMEOUT_CYC),
   parameter logic [13:0] SETTLE_CYCLES =
      14'(pulse_count_led_config_pkg::MODE_SETTLE_CYC)
) (
   input wire logic clk,
   input wire logic nrst,
   // single control pin from the host
   input wire logic ctrlPin,
   // cathode below pump_mode_threshold, one per channel
   input wire logic [3:0] cathodeLow,
   input wire logic regulatorAEnableIn,
   input wire logic regulatorBEnableIn,
   output logic pumpEnable,
   output pulse_count_led_config_pkg::pump_mode_e pumpMode,
   output pulse_count_led_config_pkg::scale_e scaleSel,
   output logic lowMode,
   output logic [3:0] levelCode,
   output logic [3:0] sinkCode,
   output logic [3:0] channelOn,
   output logic regulatorAOn,
   output logic regulatorBOn,
   output logic shutdown
);
   import pulse_count_led_config_pkg::*;

   // reset release synchroniser
   logic nrstMeta_r;
   logic nrstSync_r;
   // link state
   link_state_e state_r, state_nxt;
   logic pinPrev_r, pinPrev_nxt;
   logic [4:0] edgeCnt_r, edgeCnt_nxt;
   logic [13:0] highCnt_r, highCnt_nxt;
   logic [13:0] lowCnt_r, lowCnt_nxt;
   logic [3:0] addr_r, addr_nxt;
   // configuration fields, each data minus one
   logic [3:0] level_r, level_nxt;
   logic [3:0] scale_r, scale_nxt;
   logic [3:0] low_r, low_nxt;
   logic [3:0] chan_r, chan_nxt;
   // pump gain sequencing
   pump_mode_e pump_r, pump_nxt;
   logic [13:0] settle_r, settle_nxt;
   // output flops
   logic pumpEn_r, pumpEn_nxt;
   scale_e scaleOut_r, scaleOut_nxt;
   logic lowOut_r, lowOut_nxt;
   logic [3:0] levelOut_r, levelOut_nxt;
   logic [3:0] sinkOut_r, sinkOut_nxt;
   logic [3:0] chanOut_r, chanOut_nxt;
   logic regA_r, regA_nxt;
   logic regB_r, regB_nxt;
   logic off_r, off_nxt;
   // helpers
   logic rise;
   logic latchNow;
   logic offNow;
   logic [4:0] addrEdges;

   // reset: async assert, release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nrstMeta_r <= 1'b0;
         nrstSync_r <= 1'b0;
      end else begin
         // release only after two clean edges
         nrstMeta_r <= 1'b1;
         nrstSync_r <= nrstMeta_r;
      end
   end

   // edge counting, timeouts, address and data decode
   always_comb begin
      // a rising edge is high now after low at the last edge
      rise = ctrlPin && !pinPrev_r;
      // high held for the full latch timeout with a count pending
      latchNow = ctrlPin && (highCnt_r == LATCH_CYCLES - 14'h0001) &&
         (edgeCnt_r != 5'h00);
      // low held for the full off timeout while active
      offNow = !ctrlPin && (lowCnt_r == OFF_CYCLES - 14'h0001) &&
         (state_r == LINK_ON);
      // address is the count less the base of seventeen
      addrEdges = edgeCnt_r - ADDR_BASE_EDGES;
      state_nxt = state_r;
      pinPrev_nxt = ctrlPin;
      edgeCnt_nxt = edgeCnt_r;
      highCnt_nxt = 14'h0000;
      lowCnt_nxt = 14'h0000;
      addr_nxt = addr_r;
      level_nxt = level_r;
      scale_nxt = scale_r;
      low_nxt = low_r;
      chan_nxt = chan_r;
      // high and low timers restart on each level change
      if (ctrlPin) begin
         // saturate so a long hold cannot latch twice
         if (highCnt_r != LATCH_CYCLES) begin
            highCnt_nxt = highCnt_r + 14'h0001;
         end else begin
            highCnt_nxt = highCnt_r;
         end
      end else begin
         // saturate so a long low cannot wrap around
         if (lowCnt_r != OFF_CYCLES) begin
            lowCnt_nxt = lowCnt_r + 14'h0001;
         end else begin
            lowCnt_nxt = lowCnt_r;
         end
      end
      // count rising edges, saturating
      if (rise) begin
         state_nxt = LINK_ON;
         // an overlong burst stays at the top count
         if (edgeCnt_r != EDGE_MAX) begin
            edgeCnt_nxt = edgeCnt_r + 5'h01;
         end
      end
      if (latchNow) begin
         // the burst is used up, the next one counts from zero
         edgeCnt_nxt = 5'h00;
         if (edgeCnt_r >= ADDR_BASE_EDGES) begin
            // address burst; unmapped ones are kept but write nothing
            addr_nxt = addrEdges[3:0];
         end else if (edgeCnt_r <= DATA_MAX_EDGES) begin
            // data burst to the held address, address stays
            case (addr_r)
               ADDR_COMMON_LEVEL: begin
                  // every level code is legal
                  level_nxt = 4'(edgeCnt_r - 5'h01);
               end
               ADDR_SCALE: begin
                  // data 5..16 is not a scale and is dropped
                  if (4'(edgeCnt_r - 5'h01) <= SCALE_MAX_FIELD) begin
                     scale_nxt = 4'(edgeCnt_r - 5'h01);
                  end
               end
               ADDR_LOW_LEVEL: begin
                  // data 5..16 is not a low level and is dropped
                  if (4'(edgeCnt_r - 5'h01) <= LOW_MAX_FIELD) begin
                     low_nxt = 4'(edgeCnt_r - 5'h01);
                  end
               end
               ADDR_CHAN_EN: begin
                  // every pattern from all on to all off is legal
                  chan_nxt = 4'(edgeCnt_r - 5'h01);
               end
               default: begin
                  // unmapped address, nothing changes
                  addr_nxt = addr_r;
               end
            endcase
         end
      end
      // shutdown clears the link state, count, address and every field to its start value
      if (offNow) begin
         state_nxt = LINK_OFF;
         edgeCnt_nxt = 5'h00;
         addr_nxt = ADDR_RESET;
         level_nxt = DATA_RESET_FIELD;
         scale_nxt = DATA_RESET_FIELD;
         low_nxt = DATA_RESET_FIELD;
         chan_nxt = DATA_RESET_FIELD;
      end
   end

   // link and configuration registers
   always_ff @(posedge clk or negedge nrstSync_r) begin
      if (!nrstSync_r) begin
         state_r <= LINK_OFF;
         pinPrev_r <= 1'b0;
         edgeCnt_r <= 5'h00;
         highCnt_r <= 14'h0000;
         lowCnt_r <= 14'h0000;
         addr_r <= ADDR_RESET;
         level_r <= DATA_RESET_FIELD;
         scale_r <= DATA_RESET_FIELD;
         low_r <= DATA_RESET_FIELD;
         chan_r <= DATA_RESET_FIELD;
      end else begin
         state_r <= state_nxt;
         pinPrev_r <= pinPrev_nxt;
         edgeCnt_r <= edgeCnt_nxt;
         highCnt_r <= highCnt_nxt;
         lowCnt_r <= lowCnt_nxt;
         addr_r <= addr_nxt;
         level_r <= level_nxt;
         scale_r <= scale_nxt;
         low_r <= low_nxt;
         chan_r <= chan_nxt;
      end
   end

   // pump gain: a cathode held low for the settle time steps up once
   always_comb begin
      pump_nxt = pump_r;
      // settle count restarts whenever no cathode is low
      settle_nxt = 14'h0000;
      if (state_r != LINK_ON) begin
         // pump off, next start is in 1X
         pump_nxt = PUMP_1X;
      end else if (|cathodeLow) begin
         // a floating unused pin stays low and walks up to 2X
         if (settle_r == SETTLE_CYCLES - 14'h0001) begin
            case (pump_r)
               PUMP_1X: begin
                  pump_nxt = PUMP_1P5X;
               end
               PUMP_1P5X: begin
                  pump_nxt = PUMP_2X;
               end
               PUMP_2X: begin
                  // top gain, nothing above it
                  pump_nxt = PUMP_2X;
               end
               default: begin
                  // unused code, restart from the lowest gain
                  pump_nxt = PUMP_1X;
               end
            endcase
         end else begin
            // not settled yet, keep counting
            settle_nxt = settle_r + 14'h0001;
         end
      end
   end

   // pump registers
   always_ff @(posedge clk or negedge nrstSync_r) begin
      if (!nrstSync_r) begin
         pump_r <= PUMP_1X;
         settle_r <= 14'h0000;
      end else begin
         pump_r <= pump_nxt;
         settle_r <= settle_nxt;
      end
   end

   // output decode from the stored fields
   always_comb begin
      pumpEn_nxt = (state_r == LINK_ON);
      off_nxt = (state_r != LINK_ON);
      // exactly one scale bit set at any time
      case (scale_r)
         4'h1: scaleOut_nxt = SCALE_30MA;
         4'h2: scaleOut_nxt = SCALE_15MA;
         4'h3: scaleOut_nxt = SCALE_LOW;
         default: scaleOut_nxt = SCALE_20MA;
      endcase
      // low mode is the last of the four scale choices
      lowOut_nxt = (scale_r == SCALE_MAX_FIELD);
      levelOut_nxt = level_r;
      // low mode takes its level from the low-current field
      sinkOut_nxt = lowOut_nxt ? low_r : level_r;
      // enables are the inverse of data minus one, channel 4 the msb
      // all channels go dark while the link is off
      chanOut_nxt = off_nxt ? 4'h0 : ~chan_r;
      // regulators follow their own pins only
      regA_nxt = regulatorAEnableIn;
      regB_nxt = regulatorBEnableIn;
   end

   // output flops
   always_ff @(posedge clk or negedge nrstSync_r) begin
      if (!nrstSync_r) begin
         // outputs come up dark, in shutdown, at the 20 mA scale
         pumpEn_r <= 1'b0;
         off_r <= 1'b1;
         scaleOut_r <= SCALE_20MA;
         lowOut_r <= 1'b0;
         levelOut_r <= DATA_RESET_FIELD;
         sinkOut_r <= DATA_RESET_FIELD;
         chanOut_r <= 4'h0;
         regA_r <= 1'b0;
         regB_r <= 1'b0;
      end else begin
         pumpEn_r <= pumpEn_nxt;
         off_r <= off_nxt;
         scaleOut_r <= scaleOut_nxt;
         lowOut_r <= lowOut_nxt;
         levelOut_r <= levelOut_nxt;
         sinkOut_r <= sinkOut_nxt;
         chanOut_r <= chanOut_nxt;
         regA_r <= regA_nxt;
         regB_r <= regB_nxt;
      end
   end

   // ports straight from flops
   assign pumpEnable = pumpEn_r;
   assign pumpMode = pump_r;
   assign scaleSel = scaleOut_r;
   assign lowMode = lowOut_r;
   assign levelCode = levelOut_r;
   assign sinkCode = sinkOut_r;
   assign channelOn = chanOut_r;
   assign regulatorAOn = regA_r;
   assign regulatorBOn = regB_r;
   assign shutdown = off_r;
endmodule : pulse_count_led_config
`default_nettype wire

// File: verification/pulse_count_led_config_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_count_led_config_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ctrlPin,
   input wire logic [3:0] cathodeLow,
   input wire logic regulatorAEnableIn,
   input wire logic regulatorBEnableIn,
   input wire logic pumpEnable,
   input wire pulse_count_led_config_pkg::pump_mode_e pumpMode,
   input wire pulse_count_led_config_pkg::scale_e scaleSel,
   input wire logic lowMode,
   input wire logic [3:0] levelCode,
   input wire logic [3:0] sinkCode,
   input wire logic [3:0] channelOn,
   input wire logic regulatorAOn,
   input wire logic regulatorBOn,
   input wire logic shutdown
);
   import pulse_count_led_config_pkg::*;
   logic [1:0] upCnt_r; // edges since reset release
   logic [1:0] upCnt_nxt; // saturating next count
   logic up; // reset synchroniser has let go
   // count out the two-flop release
   always_comb begin
      up = (upCnt_r == 2'h3);
      upCnt_nxt = up ? upCnt_r : upCnt_r + 2'h1;
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) upCnt_r <= 2'h0;
      else upCnt_r <= upCnt_nxt;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_scale_onehot: assert property ($onehot(scaleSel))
      else $error("scale select not one-hot");
   chk_shut_dark: assert property (shutdown |-> channelOn == 4'h0)
      else $error("channels lit in shutdown");
   chk_shut_pump: assert property (up && shutdown |->
      !pumpEnable && pumpMode == PUMP_1X) else $error("pump on in shutdown");
   chk_shut_regs: assert property (up && shutdown |->
      levelCode == 4'h0 && scaleSel == SCALE_20MA && !lowMode)
      else $error("registers not cleared in shutdown");
   chk_low_sink: assert property (lowMode |-> sinkCode <= 4'h3)
      else $error("low mode sink out of range");
   chk_norm_sink: assert property (!lowMode |-> sinkCode == levelCode)
      else $error("sink differs from level");
   chk_reg_follow: assert property (up |=>
      regulatorAOn == $past(regulatorAEnableIn) &&
      regulatorBOn == $past(regulatorBEnableIn))
      else $error("regulator outputs do not follow pins");
   chk_pump_step: assert property (up && $changed(pumpMode) && !shutdown
      |-> pumpMode == 3'($past(pumpMode) << 1))
      else $error("pump mode moved other than one step up");
   chk_wake_pump: assert property (up && $rose(ctrlPin) |->
      ##2 pumpEnable) else $error("pump not enabled after a rising edge");
   chk_pump_cause: assert property (up && cathodeLow == 4'h0 |=>
      $stable(pumpMode) || pumpMode == PUMP_1X)
      else $error("pump stepped with no cathode low");
   cover property (pumpMode == PUMP_2X);
   cover property (lowMode);
   cover property ($fell(shutdown));
endmodule : pulse_count_led_config_monitor
bind pulse_count_led_config pulse_count_led_config_monitor mon (
   .clk(clk), .nrst(nrst), .ctrlPin(ctrlPin), .cathodeLow(cathodeLow),
   .regulatorAEnableIn(regulatorAEnableIn),
   .regulatorBEnableIn(regulatorBEnableIn), .pumpEnable(pumpEnable),
   .pumpMode(pumpMode), .scaleSel(scaleSel), .lowMode(lowMode),
   .levelCode(levelCode), .sinkCode(sinkCode), .channelOn(channelOn),
   .regulatorAOn(regulatorAOn), .regulatorBOn(regulatorBOn),
   .shutdown(shutdown));
`default_nettype wire

// File: verification/pulse_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_host_model #(
   parameter int HOLD = 26
) (
   input wire logic clk,
   output var logic ctrlPin
);
   // pin starts low so the device sits in shutdown
   initial ctrlPin = 1'b0;
   // n short pulses, pin left high on the last rising edge
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk) ctrlPin <= 1'b0;
         @(posedge clk);
         @(posedge clk) ctrlPin <= 1'b1;
         @(posedge clk);
      end
   endtask : pulses
   // n short pulses, then held high past the latch timeout
   task automatic send(input int n);
      pulses(n);
      repeat (HOLD) @(posedge clk);
   endtask : send
   // held low past the off timeout
   task automatic sleepOff();
      @(posedge clk) ctrlPin <= 1'b0;
      repeat (HOLD) @(posedge clk);
   endtask : sleepOff
endmodule : pulse_host_model
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nFail++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
   import pulse_count_led_config_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ctrlPin;
   logic [3:0] cathodeLow = 4'h0;
   logic regA = 1'b0;
   logic regB = 1'b0;
   logic pumpEnable, lowMode, regulatorAOn, regulatorBOn, shutdown;
   pump_mode_e pumpMode;
   scale_e scaleSel;
   logic [3:0] levelCode, sinkCode, channelOn;
   int nFail = 0;
   int checksDone = 0;
   int cyc = 0;
   int lvl;
   always #25 clk = ~clk;
   pulse_host_model #(.HOLD(26)) host (.clk(clk), .ctrlPin(ctrlPin));
   pulse_count_led_config #(.LATCH_CYCLES(14'h14), .OFF_CYCLES(14'h14),
      .SETTLE_CYCLES(14'h4)) uut (.clk(clk), .nrst(nrst),
      .ctrlPin(ctrlPin), .cathodeLow(cathodeLow),
      .regulatorAEnableIn(regA), .regulatorBEnableIn(regB),
      .pumpEnable(pumpEnable), .pumpMode(pumpMode), .scaleSel(scaleSel),
      .lowMode(lowMode), .levelCode(levelCode), .sinkCode(sinkCode),
      .channelOn(channelOn), .regulatorAOn(regulatorAOn),
      .regulatorBOn(regulatorBOn), .shutdown(shutdown));
   // counts, verdict, end of run
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : printVerdict
   // field a data value lands in: data 1 is field 0
   function automatic logic [3:0] fieldOf(input int d);
      return 4'(d - 1);
   endfunction : fieldOf
   // scale select that an address 3 data value asks for
   function automatic scale_e scaleOf(input int d);
      case (d)
         2: return SCALE_30MA;
         3: return SCALE_15MA;
         4: return SCALE_LOW;
         default: return SCALE_20MA;
      endcase
   endfunction : scaleOf
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         nFail++;
         printVerdict();
      end
   end
   // optional address burst, then data burst; sample settled outputs
   task automatic wr(input int a, input int d);
      if (a >= 0) host.send(17 + a);
      host.send(d);
      @(negedge clk);
   endtask : wr
   initial begin
      void'($urandom(32'hD007));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK("shutdown", 1'b1, shutdown)
      `CHK("scale", SCALE_20MA, scaleSel)
      `CHK("pump", PUMP_1X, pumpMode)
      `CHK("pumpOff", 1'b0, pumpEnable)
      `CHK("dark", 4'h0, channelOn)
      $display("reset test done");
      // common level, later writes reuse the held address
      for (int i = 0; i < 6; i++) begin
         lvl = (i == 0) ? 1 : (i == 1) ? 16 : $urandom_range(16, 1);
         wr(i == 0 ? 0 : -1, lvl);
         `CHK("level", fieldOf(lvl), levelCode)
         `CHK("pumpOn", 1'b1, pumpEnable)
         `CHK("awake", 1'b0, shutdown)
      end
      // a high shorter than the latch timeout latches nothing yet
      host.pulses(2);
      repeat (12) @(posedge clk);
      @(negedge clk);
      `CHK("early", fieldOf(lvl), levelCode)
      repeat (12) @(posedge clk);
      @(negedge clk);
      `CHK("late", fieldOf(2), levelCode)
      lvl = 2;
      $display("level test done");
      // every scale code, then low levels including an illegal one
      for (int s = 1; s <= 4; s++) begin
         wr(s == 1 ? 3 : -1, s);
         `CHK("scale", scaleOf(s), scaleSel)
         `CHK("lowMode", s == 4, lowMode)
      end
      for (int s = 1; s <= 5; s++) begin
         wr(s == 1 ? 4 : -1, s);
         `CHK("lowSink", fieldOf(s < 5 ? s : 4), sinkCode)
      end
      wr(3, 1);
      `CHK("sink", fieldOf(lvl), sinkCode)
      $display("scale test done");
      // all sixteen enable patterns
      for (int d = 1; d <= 16; d++) begin
         wr(d == 1 ? 5 : -1, d);
         `CHK("chan", ~fieldOf(d), channelOn)
      end
      // unmapped address swallows data
      wr(1, 9);
      `CHK("unmapped", fieldOf(lvl), levelCode)
      `CHK("unmappedScale", SCALE_20MA, scaleSel)
      $display("enable test done");
      // a low cathode steps the pump up once per interval
      @(posedge clk) cathodeLow <= 4'(1 << $urandom_range(3, 0));
      repeat (6) @(posedge clk);
      @(negedge clk);
      `CHK("pump15", PUMP_1P5X, pumpMode)
      repeat (20) @(posedge clk);
      @(negedge clk);
      `CHK("pump2", PUMP_2X, pumpMode)
      // regulator pins pass straight through
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) {regA, regB} <= 2'($urandom);
         @(posedge clk);
         @(negedge clk);
         `CHK("regs", {regA, regB}, {regulatorAOn, regulatorBOn})
      end
      $display("pump test done");
      // shutdown clears, wake-up data goes to address 0
      host.sleepOff();
      @(negedge clk);
      `CHK("off", 1'b1, shutdown)
      `CHK("offPump", PUMP_1X, pumpMode)
      `CHK("offPumpEn", 1'b0, pumpEnable)
      `CHK("offDark", 4'h0, channelOn)
      wr(-1, 5);
      `CHK("wakeLevel", 4'h4, levelCode)
      `CHK("wakeScale", SCALE_20MA, scaleSel)
      `CHK("wakeChan", 4'hF, channelOn)
      wr(3, 4);
      `CHK("wakeLow", fieldOf(1), sinkCode)
      `CHK("wakeLowMode", 1'b1, lowMode)
      $display("shutdown test done");
      printVerdict();
   end
endmodule : tb
`default_nettype wire
